// ### verilog/i2ce_map.svh
// Contract
// RULE_01 - Master sends START, address, direction bit
// RULE_02 - Addressed slave drives acknowledge low
// RULE_03 - Direction bit picks master and slave roles
// RULE_04 - Address and data shifted MSB first
// RULE_05 - START and STOP are SDA edges, SCL high
// RULE_06 - Receiving slave acknowledges every written byte; as slave the engine does not acknowledge when its receive buffer is full
// RULE_07 - Master acknowledges read bytes except last
// RULE_08 - Master ends with STOP or repeated START
// RULE_09 - Each combined segment opens with START, address
// RULE_10 - Master places any 7-bit target address
// RULE_11 - Own slave address, default 40h, set once
// RULE_12 - Standard SCL period 8(1+N), high 4(1+N)
// RULE_13 - Fast SCL period 6(1+N), high 2(1+N)
// RULE_14 - SDA setup and hold 2(1+N) cycles
// RULE_15 - START hold 4(1+N), STOP setup 2(1+N)
// RULE_16 - Bus free 4(1+N) between STOP, START
// RULE_17 - Slave accepts SCL period 12, high 1
// RULE_18 - Slave output held 4 cycles after fall
// RULE_19 - Slave needs SDA valid one cycle past fall
// RULE_20 - Divide value accepts 1 to 255
// RULE_21 - Timing unit is one core clock cycle
// RULE_22 - Phase count 8 below 100 kHz, else 6
// RULE_23 - SCL open-drain as master, input as slave
// RULE_24 - Unmatched slave address ignored until START/STOP
// RULE_25 - Master flags missing acknowledge, sends STOP
`ifndef I2CE_MAP_SVH
`define I2CE_MAP_SVH
// Core clock period, ns
`define I2CE_CORE_PERIOD_NS 10
`define I2CE_OWN_ADDR_RST 7'h40
`define I2CE_N_MIN 8'h01
// Phase counts per SCL period
`define I2CE_PHASE_STD 4'h8
`define I2CE_PHASE_FAST 4'h6
// Ticks of (1+N) core cycles
`define I2CE_LO_TICKS 3'h4
`define I2CE_SETUP_TICKS 3'h2
`define I2CE_START_HOLD 3'h4
`define I2CE_STOP_SETUP 3'h2
`define I2CE_FREE_TICKS 3'h4
// Slave output hold, core cycles
`define I2CE_SLV_HOLD 3'h4
`define I2CE_LAST_BIT 4'h7
`define I2CE_ACK_BIT 4'h8
// Slave bit count at START; the START's own SCL fall wraps it to 0
`define I2CE_SB_START 4'hf
`define I2CE_IDLE_BYTE 8'hff
`define I2CE_BYTE_W 8
`define I2CE_FIFO_DEPTH 8
`endif

// ### verilog/i2ce_pkg.sv
package i2ce_pkg;
	// Master sequencer states
	typedef enum logic [2:0] {
		M_IDLE, M_START, M_LO, M_HI, M_STOP, M_FREE, M_HOLD, M_RS
	} i2ce_mst_t;
	// Slave tracker states
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_RX, S_TX, S_IGN
	} i2ce_slv_t;
	// Whole engine state
	typedef struct packed {
		i2ce_mst_t st;
		logic [7:0] pre;
		logic [2:0] tk;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic [7:0] len;
		logic rd;
		logic dat;
		logic stp;
		logic m_scl;
		logic m_sda;
		logic err;
		logic done;
		i2ce_slv_t sst;
		logic [3:0] sb;
		logic [7:0] ss;
		logic s_oe;
		logic s_want;
		logic [2:0] s_dly;
		logic sp;
		logic dp;
		logic [6:0] oa;
		logic oa_lock;
		logic sdet;
		logic pdet;
	} i2ce_state_t;
endpackage : i2ce_pkg

// ### verilog/i2ce_fifo_if.sv
`timescale 1ns/10ps
interface i2ce_fifo_if #(parameter int W = 8);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	// Producer side
	modport fill (output push_valid, push_data, input push_ready);
	// Consumer side
	modport drain (input pop_valid, pop_data, output pop_ready);
	// The buffer itself
	modport store (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
endinterface : i2ce_fifo_if

// ### verilog/i2ce_fifo.sv
`timescale 1ns/10ps
`include "i2ce_map.svh"
module i2ce_fifo #(
	parameter int W = `I2CE_BYTE_W,
	parameter int DEPTH = `I2CE_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	i2ce_fifo_if.store io
);
	import i2ce_pkg::*;
	// Pointers wrap freely, so DEPTH must be a power of two
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} i2ce_fifo_st_t;
	i2ce_fifo_st_t q, d;
	logic do_push;
	logic do_pop;
	// Frozen clock enable refuses both sides
	assign io.push_ready = clk_en && (q.cnt != (AW+1)'(DEPTH));
	assign io.pop_valid = clk_en && (q.cnt != '0);
	assign io.pop_data = q.mem[q.rp];
	assign do_push = io.push_valid && io.push_ready;
	assign do_pop = io.pop_valid && io.pop_ready;
	// Next state of storage and pointers
	always_comb begin
		d = q;
		if (do_push) begin
			d.mem[q.wp] = io.push_data;
			d.wp = q.wp + 1'b1;
		end
		if (do_pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end
endmodule : i2ce_fifo

// ### verilog/i2ce_engine.sv
`timescale 1ns/10ps
`include "i2ce_map.svh"
module i2ce_engine (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic mode_master,
	input wire logic speed_std,
	input wire logic [7:0] divide_value,
	input wire logic own_addr_wr,
	input wire logic [6:0] own_addr_val,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [6:0] cmd_addr,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_len,
	input wire logic cmd_stop,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic busy,
	output logic nack_err,
	output logic xfer_done,
	output logic start_seen,
	output logic stop_seen
);
	import i2ce_pkg::*;

	// Reset image; bus lines assumed high at reset
	localparam i2ce_state_t RST = '{st: M_IDLE, sst: S_IDLE,
		oa: `I2CE_OWN_ADDR_RST, sp: 1'b1, dp: 1'b1, default: '0};

	i2ce_state_t q, d;
	logic tick; // One unit of (1+N) core cycles elapsed
	logic [2:0] tkn; // Tick count after this tick
	logic [7:0] nval; // Clamped divide value
	logic [2:0] hi; // High phase length in ticks
	logic stall; // Master waits on a stream
	logic rise, fall, sta, sto; // Slave-side bus events
	logic push_v; // Byte offered to receive buffer
	logic [7:0] push_d;
	logic push_ready;
	logic tx_take; // Transmit byte accepted this cycle
	logic m_nack; // Master saw no acknowledge
	logic cmd_go;

	i2ce_fifo_if #(.W(`I2CE_BYTE_W)) rxq ();

	// Received bytes wait here; a full buffer stalls the master
	i2ce_fifo #(.W(`I2CE_BYTE_W), .DEPTH(`I2CE_FIFO_DEPTH)) u_rxq (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.io(rxq.store)
	);
	assign rxq.push_valid = push_v && clk_en;
	assign rxq.push_data = push_d;
	assign push_ready = rxq.push_ready;
	assign rx_valid = rxq.pop_valid;
	assign rx_data = rxq.pop_data;
	assign rxq.pop_ready = rx_ready;

	// Commands only at idle, or while holding the bus for a restart
	assign cmd_ready = clk_en && mode_master && (q.st == M_IDLE ||
		(q.st == M_HOLD && !q.m_sda));
	assign cmd_go = cmd_valid && cmd_ready;
	assign tx_ready = clk_en && tx_take;

	// Pins are open-drain: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = q.m_scl; // [RULE_23]
	assign sda_oe = q.m_sda || q.s_oe; // [RULE_23]
	assign busy = (q.st != M_IDLE) || (q.sst != S_IDLE);
	assign nack_err = q.err;
	assign xfer_done = q.done;
	assign start_seen = q.sdet;
	assign stop_seen = q.pdet;

	// Next-state logic for master sequencer and slave tracker
	always_comb begin
		d = q;
		d.err = 1'b0;
		d.done = 1'b0;
		d.sdet = 1'b0;
		d.pdet = 1'b0;
		push_v = 1'b0;
		push_d = q.ss;
		tx_take = 1'b0;
		m_nack = 1'b0;
		// Zero is out of range, run it as the fastest legal
		nval = (divide_value < `I2CE_N_MIN) ? `I2CE_N_MIN :
			divide_value; // [RULE_20]
		// Low phase is always 4 ticks; high is the rest
		hi = 3'((speed_std ? `I2CE_PHASE_STD : `I2CE_PHASE_FAST) -
			4'(`I2CE_LO_TICKS)); // [RULE_22] [RULE_12] [RULE_13]
		tick = (q.pre == nval); // [RULE_21]
		tkn = q.tk + 3'h1;
		// Edges judged from last cycle's sample
		rise = scl_i && !q.sp; // [RULE_17]
		fall = !scl_i && q.sp;
		sta = scl_i && q.sp && q.dp && !sda_i; // [RULE_05]
		sto = scl_i && q.sp && !q.dp && sda_i; // [RULE_05]
		d.sp = scl_i;
		d.dp = sda_i;

		// Own address takes one write only, then locks
		if (own_addr_wr && !q.oa_lock) begin // [RULE_11]
			d.oa = own_addr_val;
			d.oa_lock = 1'b1;
		end

		// Hold SCL low while a stream is not ready
		stall = 1'b0;
		if (q.st == M_LO && tick && tkn == `I2CE_SETUP_TICKS) begin
			if (q.dat && !q.rd && q.bitn == 4'h0 && !tx_valid) begin
				stall = 1'b1;
			end
			if (q.dat && q.rd && q.bitn == `I2CE_ACK_BIT &&
				!push_ready) begin
				stall = 1'b1;
			end
		end
		// Unit prescaler; parks on its last count when stalled
		if (q.st != M_IDLE && !stall) begin
			if (tick) begin
				d.pre = '0;
				d.tk = tkn;
			end else begin
				d.pre = q.pre + 8'h01;
			end
		end

		case (q.st)
			M_HOLD: begin
				// Bus kept: SCL low, SDA let go
				if (tick && tkn == `I2CE_SETUP_TICKS) begin
					d.m_sda = 1'b0;
				end
			end
			M_START: begin
				if (tick && tkn == `I2CE_START_HOLD) begin // [RULE_15]
					d.m_scl = 1'b1;
					d.st = M_LO;
					d.tk = '0;
				end
			end
			M_RS: begin
				// Repeated START: raise SCL, then drop SDA
				if (tick && tkn == `I2CE_LO_TICKS) begin
					d.m_scl = 1'b0;
				end
				if (tick && tkn == `I2CE_LO_TICKS + `I2CE_SETUP_TICKS) begin
					d.m_sda = 1'b1; // [RULE_09]
					d.st = M_START;
					d.tk = '0;
				end
			end
			M_LO: begin
				// SDA moves mid-low: hold after fall, setup before rise
				if (tick && !stall && tkn == `I2CE_SETUP_TICKS) begin
					if (q.dat && !q.rd && q.bitn == 4'h0) begin
						d.sh = tx_data;
						tx_take = 1'b1;
						d.m_sda = !tx_data[7]; // [RULE_04] [RULE_14]
					end else if (q.bitn == `I2CE_ACK_BIT) begin
						// Acknowledge all reads but the last
						d.m_sda = q.dat && q.rd && q.len != 8'h01; // [RULE_07]
						if (q.dat && q.rd) begin
							push_v = 1'b1;
							push_d = q.sh;
						end
					end else if (q.dat && q.rd) begin
						d.m_sda = 1'b0; // [RULE_03]
					end else begin
						d.m_sda = !q.sh[7]; // [RULE_04] [RULE_14]
					end
				end
				if (tick && tkn == `I2CE_LO_TICKS) begin
					d.m_scl = 1'b0;
					d.st = M_HI;
					d.tk = '0;
				end
			end
			M_HI: begin
				// Sample at the end of high; no stretching honoured
				if (tick && tkn == hi) begin
					d.m_scl = 1'b1;
					d.st = M_LO;
					d.tk = '0;
					if (q.bitn != `I2CE_ACK_BIT) begin
						d.bitn = q.bitn + 4'h1;
						d.sh = {q.sh[6:0], q.dat && q.rd && sda_i}; // [RULE_04]
					end else begin
						d.bitn = '0;
						if (!(q.dat && q.rd) && sda_i) begin
							m_nack = 1'b1; // [RULE_25] [RULE_06]
							d.err = 1'b1;
							d.st = M_STOP;
						end else if (!q.dat && q.len == 8'h00) begin
							d.done = 1'b1;
							d.st = q.stp ? M_STOP : M_HOLD; // [RULE_08]
						end else begin
							d.dat = 1'b1; // [RULE_03]
							if (q.dat) begin
								d.len = q.len - 8'h01;
							end
							if (q.dat && q.len == 8'h01) begin
								d.done = 1'b1;
								d.st = q.stp ? M_STOP : M_HOLD; // [RULE_08]
							end
						end
					end
				end
			end
			M_STOP: begin
				// SDA low, SCL up, then SDA up while SCL high
				if (tick && tkn == `I2CE_SETUP_TICKS) begin
					d.m_sda = 1'b1;
				end
				if (tick && tkn == `I2CE_LO_TICKS) begin
					d.m_scl = 1'b0;
				end
				if (tick && tkn == `I2CE_LO_TICKS + `I2CE_STOP_SETUP) begin
					d.m_sda = 1'b0; // [RULE_05] [RULE_15]
					d.st = M_FREE;
					d.tk = '0;
				end
			end
			M_FREE: begin
				if (tick && tkn == `I2CE_FREE_TICKS) begin // [RULE_16]
					d.st = M_IDLE;
				end
			end
			M_IDLE: begin
				d.pre = '0;
			end
			default: begin
				d.st = M_IDLE;
			end
		endcase

		// New segment: START then address and direction
		if (cmd_go) begin
			d.sh = {cmd_addr, cmd_read}; // [RULE_01] [RULE_10]
			d.rd = cmd_read;
			d.len = cmd_len;
			d.stp = cmd_stop;
			d.dat = 1'b0;
			d.bitn = '0;
			d.tk = '0;
			d.pre = '0;
			d.m_sda = (q.st == M_IDLE); // [RULE_05]
			d.st = (q.st == M_IDLE) ? M_START : M_RS; // [RULE_09]
		end

		// Leaving master mode lets go of both lines
		if (!mode_master) begin
			d.st = M_IDLE;
			d.m_scl = 1'b0;
			d.m_sda = 1'b0;
		end

		// Slave tracker; SCL is never driven here
		if (!mode_master) begin
			if (q.s_dly != 3'h0) begin
				d.s_dly = q.s_dly - 3'h1;
				if (q.s_dly == 3'h1) begin
					d.s_oe = q.s_want; // [RULE_18]
				end
			end
			if (rise) begin
				if (q.sb != `I2CE_ACK_BIT && q.sst != S_TX) begin
					d.ss = {q.ss[6:0], sda_i}; // [RULE_04] [RULE_19]
				end
				// Master refused our byte: drop off the bus
				if (q.sb == `I2CE_ACK_BIT && q.sst == S_TX && sda_i) begin
					d.sst = S_IGN;
				end
			end
			if (fall) begin
				d.s_dly = `I2CE_SLV_HOLD - 3'h1; // [RULE_18]
				d.s_want = 1'b0;
				if (q.sb == `I2CE_LAST_BIT) begin
					d.sb = `I2CE_ACK_BIT;
					case (q.sst)
						S_ADDR: begin
							if (q.ss[7:1] == q.oa) begin
								d.s_want = 1'b1; // [RULE_02] [RULE_11]
								d.sst = q.ss[0] ? S_TX : S_RX; // [RULE_03]
							end else begin
								d.sst = S_IGN; // [RULE_24]
							end
						end
						S_RX: begin
							// Full buffer answers with no acknowledge
							if (push_ready) begin
								push_v = 1'b1;
								d.s_want = 1'b1; // [RULE_06]
							end
						end
						default: begin
							d.s_want = 1'b0;
						end
					endcase
				end else if (q.sb == `I2CE_ACK_BIT) begin
					d.sb = '0;
					if (q.sst == S_TX) begin
						// Empty stream sends all ones
						tx_take = 1'b1;
						d.ss = tx_valid ? tx_data : `I2CE_IDLE_BYTE;
						// Idle byte is all ones, so nothing is driven then
						d.s_want = tx_valid && !tx_data[7]; // [RULE_04]
					end
				end else begin
					d.sb = q.sb + 4'h1;
					if (q.sst == S_TX) begin
						d.ss = {q.ss[6:0], 1'b0};
						d.s_want = !q.ss[6]; // [RULE_04]
					end
				end
			end
			if (sta) begin
				d.sst = S_ADDR; // [RULE_09] [RULE_24]
				// The SCL fall that closes the START is not a bit
				d.sb = `I2CE_SB_START;
				d.s_oe = 1'b0;
				d.s_want = 1'b0;
				d.s_dly = '0;
				d.sdet = 1'b1;
			end
			if (sto) begin
				d.sst = S_IDLE; // [RULE_24]
				d.s_oe = 1'b0;
				d.s_want = 1'b0;
				d.s_dly = '0;
				d.pdet = 1'b1;
			end
		end else begin
			d.sst = S_IDLE;
			d.s_oe = 1'b0;
			d.s_dly = '0;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// Cycles since master SCL drive last changed; checks only
	int unsigned ph_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_cnt <= 0;
		end else if (clk_en) begin
			ph_cnt <= (d.m_scl != q.m_scl) ? 0 : ph_cnt + 1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !clk_en);

	sequence m_start_s;
		mode_master && $rose(q.m_sda) && !q.m_scl;
	endsequence
	sequence cmd_take_s;
		cmd_go && q.st == M_IDLE;
	endsequence
	sequence addr_hit_s;
		!mode_master && fall && q.sst == S_ADDR &&
			q.sb == `I2CE_LAST_BIT && q.ss[7:1] == q.oa;
	endsequence
	sequence addr_miss_s;
		!mode_master && fall && q.sst == S_ADDR &&
			q.sb == `I2CE_LAST_BIT && q.ss[7:1] != q.oa;
	endsequence

	start_hold_a: assert property (m_start_s |-> !q.m_scl [*8]) // [RULE_15]
		else $error("SCL pulled low too soon after START");
	sda_move_a: assert property ( // [RULE_14]
		mode_master && $past(mode_master) && $changed(q.m_sda) &&
		!q.m_scl |-> $past(q.st) inside {M_IDLE, M_RS, M_STOP})
		else $error("master SDA moved while SCL high");
	high_len_a: assert property ( // [RULE_12] [RULE_13]
		q.st == M_HI && d.st != M_HI |->
		ph_cnt + 1 == int'(hi) * (int'(nval) + 1))
		else $error("SCL high phase length wrong");
	low_len_a: assert property ( // [RULE_14]
		q.st == M_LO && d.st == M_HI |->
		ph_cnt + 1 >= int'(`I2CE_LO_TICKS) * (int'(nval) + 1))
		else $error("SCL low phase too short");
	addr_byte_a: assert property (cmd_take_s |=> // [RULE_01] [RULE_10]
		q.sh[7:1] == $past(cmd_addr) && q.sh[0] == $past(cmd_read) &&
		q.st == M_START && q.m_sda)
		else $error("address byte or START not set up");
	master_ack_a: assert property ( // [RULE_07]
		q.st == M_HI && q.bitn == `I2CE_ACK_BIT && q.dat && q.rd |->
		q.m_sda == (q.len != 8'h01))
		else $error("read acknowledge wrong");
	nack_stop_a: assert property (m_nack |=> // [RULE_25]
		q.err && q.st == M_STOP)
		else $error("missing acknowledge not handled");
	free_time_a: assert property ( // [RULE_16]
		$past(q.st) == M_STOP && q.st == M_FREE |->
		(!q.m_sda && !q.m_scl && q.st != M_START) [*8])
		else $error("bus free time too short");
	addr_ack_a: assert property (addr_hit_s |-> ##4 q.s_oe) // [RULE_02]
		else $error("own address not acknowledged");
	no_match_a: assert property (addr_miss_s |-> // [RULE_24]
		##1 q.sst == S_IGN ##3 !q.s_oe)
		else $error("foreign address acknowledged");
	slave_hold_a: assert property ( // [RULE_18]
		$changed(q.s_oe) && !$past(sta) && !$past(sto) &&
		!$past(mode_master) |-> $past(fall, 4))
		else $error("slave SDA moved off the hold slot");
endmodule : i2ce_engine

// ### testbench/i2ce_bus_model.sv
`timescale 1ns/10ps
// Far-side slave; looks at the wires on the falling clock edge
module i2ce_bus_model #(
	parameter logic [6:0] ADDR = 7'h5b
) (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] rd_base,
	output logic sda_low
);
	logic scl_q, sda_q; // Previous wire levels
	logic act, adr, rd, mack; // Frame state
	logic [3:0] cnt; // Falls seen in this byte
	logic [7:0] sh, tx_q, nb; // Shifters
	logic [7:0] got [$]; // Bytes written to us
	int n_start, n_stop, n_tx; // Tallies read by the bench
	initial begin
		{scl_q, sda_q} = 2'h3;
		{act, adr, rd, mack, sda_low} = 5'h00;
		cnt = 4'h0;
		n_start = 0;
		n_stop = 0;
		n_tx = 0;
	end
	// Released data line floats to the pull-up level
	always @(negedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && scl_q && sda_q && !sda) begin
			{act, adr, rd} <= 3'h6;
			cnt <= 4'hf; // START's own SCL fall brings it to 0
			sda_low <= 1'b0;
			n_start++;
		end else if (scl && scl_q && !sda_q && sda) begin
			act <= 1'b0;
			sda_low <= 1'b0;
			n_stop++;
		end else if (act && scl && !scl_q) begin
			if (cnt == 4'h8) mack <= !sda; // Ack slot seen low
			else sh <= {sh[6:0], sda}; // MSB first
		end else if (act && !scl && scl_q) begin
			cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
			if (cnt == 4'h7) begin
				if (adr) begin // Address then direction
					adr <= 1'b0;
					rd <= sh[0];
					act <= (sh[7:1] == ADDR);
					sda_low <= (sh[7:1] == ADDR);
				end else if (!rd) begin // Ack each byte
					got.push_back(sh);
					sda_low <= 1'b1;
				end else sda_low <= 1'b0; // Leave slot to master
			end else if (cnt == 4'h8) begin
				if (rd && mack) begin // Send next byte
					nb = rd_base + n_tx[7:0];
					n_tx++;
					tx_q <= nb;
					sda_low <= !nb[7];
				end else begin // Nack or end of ack pulse
					act <= !rd;
					sda_low <= 1'b0;
				end
			end else if (rd && !adr) begin // Next bit
				tx_q <= tx_q << 1;
				sda_low <= !tx_q[6];
			end
		end
	end
endmodule : i2ce_bus_model

// ### testbench/i2ce_engine_tb.sv
`timescale 1ns/10ps
// Bench for the engine as bus master and as bus slave
module i2ce_engine_tb;
	localparam logic [6:0] MA = 7'h5b; // Partner address
	logic clk, rst_n, mode_master, speed_std, own_addr_wr, cmd_valid;
	logic cmd_read, cmd_stop, rx_ready, tb_scl_low, tb_sda_low;
	logic tx_valid, scl_p, hs_tx, r_a;
	logic [7:0] divide_value, cmd_len, tx_data, rx_data, r_b;
	logic [7:0] rd_base;
	logic [6:0] own_addr_val, cmd_addr;
	logic cmd_ready, tx_ready, rx_valid, scl_o, scl_oe, sda_o, sda_oe;
	logic busy, nack_err, xfer_done, start_seen, stop_seen, m_low;
	logic [7:0] txq [$]; // Bytes offered on the send port
	logic [7:0] rxq [$]; // Bytes taken from the FIFO
	int miscompares, n_compared, n_done, n_nerr, n_ss, n_ps, ev0;
	int hi_w, per, hi_c, per_c;
	wire scl_w = !(scl_oe || tb_scl_low); // Open drain, pull-up
	wire sda_w = !(sda_oe || m_low || tb_sda_low);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	i2ce_engine u_i2ce_engine (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.mode_master(mode_master), .speed_std(speed_std),
		.divide_value(divide_value), .own_addr_wr(own_addr_wr),
		.own_addr_val(own_addr_val), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
		.cmd_len(cmd_len), .cmd_stop(cmd_stop), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .busy(busy), .nack_err(nack_err),
		.xfer_done(xfer_done), .start_seen(start_seen),
		.stop_seen(stop_seen));
	i2ce_bus_model #(.ADDR(MA)) u_i2ce_bus_model (.clk(clk), .scl(scl_w),
		.sda(sda_w), .rd_base(rd_base), .sda_low(m_low));
	// Mid-cycle sampling keeps clear of edge races
	always @(negedge clk) begin
		hs_tx = tx_valid && tx_ready;
		if (rx_valid === 1'b1 && rx_ready) rxq.push_back(rx_data);
		if (xfer_done === 1'b1) n_done++;
		if (nack_err === 1'b1) n_nerr++;
		if (start_seen === 1'b1) n_ss++;
		if (stop_seen === 1'b1) n_ps++;
		hi_c++;
		per_c++;
		if (scl_w && !scl_p) {per, per_c, hi_c} = {per_c, 64'h0};
		if (!scl_w && scl_p) hi_w = hi_c;
		scl_p = scl_w;
	end
	// Retire a byte taken at this edge
	always @(posedge clk) begin
		if (hs_tx) begin
			#1;
			void'(txq.pop_front());
			tx_valid = (txq.size() > 0);
			if (tx_valid) tx_data = txq[0];
		end
	end
	task automatic wt(input int n); // Step off the edge
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("Counts: %0d compared, %0d bad", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic tx_push(input logic [7:0] b);
		txq.push_back(b);
		tx_data = txq[0];
		tx_valid = 1'b1;
	endtask : tx_push
	// Offer one command, held until taken
	task automatic m_go(input logic [6:0] a, input logic r,
		input logic [7:0] n, input logic s);
		ev0 = n_done + n_nerr;
		{cmd_addr, cmd_read, cmd_len, cmd_stop} = {a, r, n, s};
		cmd_valid = 1'b1;
		for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) wt(1);
		chk(cmd_ready, 1'b1);
		wt(1);
		cmd_valid = 1'b0;
	endtask : m_go
	task automatic m_wait; // Bounded wait for done or nack
		for (int i = 0; i < 5000 && n_done + n_nerr == ev0; i++) wt(1);
		chk(n_done + n_nerr, ev0 + 1);
	endtask : m_wait
	task automatic m_idle;
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) wt(1);
		chk(busy, 1'b0);
	endtask : m_idle
	task automatic t_write; // Standard speed, N=1
		int d0, s0;
		{d0, s0} = {n_done, u_i2ce_bus_model.n_stop};
		{speed_std, divide_value} = {1'b1, 8'h01};
		tx_push(8'ha1);
		tx_push(8'h3c);
		m_go(MA, 1'b0, 8'h02, 1'b1);
		m_wait;
		chk(n_done, d0 + 1);
		chk(hi_w, 8);
		chk(per, 16);
		m_idle;
		chk(u_i2ce_bus_model.got.size(), 2);
		chk(u_i2ce_bus_model.got[0], 8'ha1);
		chk(u_i2ce_bus_model.got[1], 8'h3c);
		chk(u_i2ce_bus_model.n_stop, s0 + 1);
	endtask : t_write
	task automatic t_read; // Fast, N=2, FIFO stall, then repeated START
		int d0, s0, p0, n0;
		d0 = n_done;
		{s0, p0} = {u_i2ce_bus_model.n_start, u_i2ce_bus_model.n_stop};
		n0 = u_i2ce_bus_model.n_tx;
		{speed_std, divide_value, rx_ready} = {1'b0, 8'h02, 1'b0};
		rxq.delete();
		m_go(MA, 1'b1, 8'h0a, 1'b0);
		wt(2500);
		chk(n_done, d0); // Stalled on a full FIFO
		chk(rx_valid, 1'b1);
		chk(scl_w, 1'b0); // Clock held low until room
		rx_ready = 1'b1;
		m_wait;
		wt(20);
		chk(rxq.size(), 10);
		for (int i = 0; i < 10; i++) chk(rxq[i], rd_base + n0 + i);
		chk(u_i2ce_bus_model.n_tx - n0, 10);
		tx_push(8'h5e);
		m_go(MA, 1'b0, 8'h01, 1'b1);
		m_wait;
		chk(hi_w, 6);
		chk(per, 18);
		m_idle;
		chk(u_i2ce_bus_model.n_start - s0, 2);
		chk(u_i2ce_bus_model.n_stop - p0, 1);
		chk(u_i2ce_bus_model.got[2], 8'h5e);
	endtask : t_read
	task automatic t_nack; // Nobody answers
		int e0, p0;
		{e0, p0} = {n_nerr, u_i2ce_bus_model.n_stop};
		m_go(7'h00, 1'b0, 8'h01, 1'b1);
		m_wait;
		chk(n_nerr, e0 + 1);
		m_idle;
		chk(u_i2ce_bus_model.n_stop - p0, 1);
		chk(sda_w, 1'b1);
	endtask : t_nack
	// Bench as bus master: 6 low, 6 high, data moved 2 after fall
	task automatic s_bit(input logic b, output logic r);
		wt(2);
		tb_sda_low = !b; // Hold past the fall
		wt(4);
		tb_scl_low = 1'b0;
		wt(5);
		r = sda_w;
		wt(1);
		tb_scl_low = 1'b1;
	endtask : s_bit
	task automatic s_byte(input logic [7:0] d, input logic a,
		output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			s_bit(d[i], b);
			r[i] = b;
		end
		s_bit(a, ack);
	endtask : s_byte
	task automatic s_edge(input logic stop); // START or STOP
		wt(2);
		tb_sda_low = stop; // Set up SDA; SCL is low here only before a STOP
		wt(4);
		tb_scl_low = 1'b0;
		wt(6);
		tb_sda_low = !stop; // SDA edge with SCL high
		wt(6);
		tb_scl_low = !stop; // START leaves SCL low
	endtask : s_edge
	task automatic t_slave_default; // Address 40h after reset
		int k0, p0;
		{k0, p0} = {n_ss, n_ps};
		mode_master = 1'b0;
		rxq.delete();
		wt(4);
		s_edge(1'b0);
		s_byte({7'h40, 1'b0}, 1'b1, r_b, r_a);
		chk(r_a, 1'b0);
		s_byte(8'h96, 1'b1, r_b, r_a);
		chk(r_a, 1'b0);
		s_edge(1'b1);
		chk(rxq.size(), 1);
		chk(rxq[0], 8'h96);
		chk(n_ss - k0, 1);
		chk(n_ps - p0, 1);
	endtask : t_slave_default
	task automatic t_slave_prog; // First address write wins
		own_addr_val = 7'h33;
		own_addr_wr = 1'b1;
		wt(1);
		own_addr_val = 7'h44;
		wt(1);
		own_addr_wr = 1'b0;
		s_edge(1'b0);
		s_byte({7'h44, 1'b0}, 1'b1, r_b, r_a);
		chk(r_a, 1'b1);
		s_byte(8'h77, 1'b1, r_b, r_a);
		chk(r_a, 1'b1);
		s_edge(1'b1);
		tx_push(8'h6d);
		s_edge(1'b0);
		s_byte({7'h33, 1'b1}, 1'b1, r_b, r_a);
		chk(r_a, 1'b0);
		s_byte(8'hff, 1'b1, r_b, r_a);
		chk(r_b, 8'h6d);
		s_edge(1'b1);
		chk(rxq.size(), 1);
		chk(txq.size(), 0);
	endtask : t_slave_prog
	initial begin
		{rst_n, mode_master, speed_std, own_addr_wr, cmd_valid} = 5'h0c;
		{cmd_read, cmd_stop, rx_ready, tb_scl_low, tb_sda_low} = 5'h00;
		{tx_valid, scl_p, hs_tx} = 3'h2;
		{divide_value, cmd_len, tx_data, rd_base} = 32'h0100_0090;
		{own_addr_val, cmd_addr} = 14'h0000;
		{miscompares, n_compared, n_done, n_nerr, n_ss, n_ps} = 192'h0;
		{hi_w, per, hi_c, per_c, ev0} = 160'h0;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		wt(2);
		t_write;
		t_read;
		t_nack;
		t_slave_default;
		t_slave_prog;
		complete_run;
	end
	initial begin // Watchdog, several times the expected run
		#600000;
		miscompares++;
		complete_run;
	end
endmodule : i2ce_engine_tb
